// ===== hw/sabc_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Low start resets conversion at third edge, after the two-flop synchronizer
// - Start high begins conversion at third edge, after the two-flop synchronizer
// - Done goes low one edge after the LSB is decided
// - Enable high puts outputs high impedance
// - Enable low drives current result out
// - Conversion finishes within 2.5 microseconds
// - Eight-bit offset binary, 0x80 mid-scale
module sabc_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host pins
    input wire logic start_n,
    input wire logic data_en_n,
    output logic eoc_n,
    output sabc_pkg::sabc_bus_t bus,
    // Comparator
    input wire logic cmp_above,
    output logic [7:0] dac_code
);
    import sabc_pkg::*;

    logic start_s;
    logic drive_s;
    logic cmp_s;
    sabc_state_t state_q;
    logic [7:0] trial_q;
    logic [7:0] mask_q;
    logic [7:0] div_q;
    logic step;

    sabc_sync u_sync_start (.clk(clk), .rst(rst), .d(start_n), .q(start_s));
    // Inverted so the reset value means outputs released
    sabc_sync u_sync_en (.clk(clk), .rst(rst), .d(!data_en_n), .q(drive_s));
    sabc_sync u_sync_cmp (.clk(clk), .rst(rst), .d(cmp_above), .q(cmp_s));

    // Bit-decision rate enable
    // Phase restarts each run so the first decision sees a settled comparator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
        end else if (!start_s || state_q != SABC_RUN || div_q == SABC_BIT_DIV) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign step = (div_q == SABC_BIT_DIV);

    // Conversion sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SABC_IDLE;
            trial_q <= SABC_RESET_CODE;
            mask_q <= 8'h00;
        end else if (!start_s) begin
            state_q <= SABC_IDLE;
            trial_q <= SABC_RESET_CODE;
            mask_q <= 8'h00;
        end else begin
            case (state_q)
                SABC_IDLE: begin
                    state_q <= SABC_RUN;
                    trial_q <= SABC_MID_CODE;
                    mask_q <= SABC_MID_CODE;
                end
                SABC_RUN: begin
                    if (step) begin
                        if (!cmp_s) begin
                            trial_q <= (trial_q & ~mask_q) | (mask_q >> 1);
                        end else begin
                            trial_q <= trial_q | (mask_q >> 1);
                        end
                        mask_q <= mask_q >> 1;
                        if (mask_q == 8'h01) begin
                            state_q <= SABC_DONE;
                        end
                    end
                end
                SABC_DONE: begin
                    state_q <= SABC_DONE;
                end
                default: begin
                    state_q <= SABC_IDLE;
                end
            endcase
        end
    end

    // Done flag and bus drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eoc_n <= 1'b1;
        end else begin
            eoc_n <= !(start_s && state_q == SABC_DONE);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.data_out <= 8'h00;
            bus.data_oe_n <= 8'hff;
            dac_code <= 8'h00;
        end else begin
            dac_code <= trial_q;
            bus.data_out <= trial_q;
            bus.data_oe_n <= {8{!drive_s}};
        end
    end

    int unsigned busy_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 0;
        end else if (state_q == SABC_RUN) begin
            busy_cnt <= busy_cnt + 1;
        end else begin
            busy_cnt <= 0;
        end
    end

    // Bits resolved in the current run
    logic [3:0] bits_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits_q <= 4'h0;
        end else if (state_q != SABC_RUN) begin
            bits_q <= 4'h0;
        end else if (step) begin
            bits_q <= bits_q + 4'h1;
        end
    end

    // Steps of a conversion
    sequence start_low_s;
        !start_s;
    endsequence

    sequence run_entry_s;
        $rose(state_q == SABC_RUN);
    endsequence

    sequence step_taken_s;
        start_s && state_q == SABC_RUN && step;
    endsequence

    sequence done_entry_s;
        start_s && $rose(state_q == SABC_DONE);
    endsequence

    sequence done_held_s;
        start_s && state_q == SABC_DONE;
    endsequence

    // Start and restart
    reset_on_low_a: assert property (@(posedge clk) disable iff (rst)
        start_low_s |=> state_q == SABC_IDLE)
        else $error("start low did not reset");
    eoc_clear_a: assert property (@(posedge clk) disable iff (rst)
        start_low_s |=> eoc_n)
        else $error("done flag not cleared by start");
    begin_on_high_a: assert property (@(posedge clk) disable iff (rst)
        (start_s && state_q == SABC_IDLE) |=> state_q == SABC_RUN)
        else $error("conversion did not begin");
    mid_start_a: assert property (@(posedge clk) disable iff (rst)
        run_entry_s |-> trial_q == SABC_MID_CODE)
        else $error("not mid-scale start");

    // Bit decisions
    run_bits_a: assert property (@(posedge clk) disable iff (rst)
        done_entry_s |-> bits_q == 4'(SABC_BITS))
        else $error("wrong number of bit decisions");
    msb_first_a: assert property (@(posedge clk) disable iff (rst)
        step_taken_s |=>
            (trial_q & ~($past(mask_q) | ($past(mask_q) >> 1))) ==
            ($past(trial_q) & ~($past(mask_q) | ($past(mask_q) >> 1))))
        else $error("decided bit changed");
    bit_clear_a: assert property (@(posedge clk) disable iff (rst)
        step_taken_s ##0 !cmp_s |=> (trial_q & $past(mask_q)) == 8'h00)
        else $error("trial bit not cleared");
    bit_keep_a: assert property (@(posedge clk) disable iff (rst)
        step_taken_s ##0 cmp_s |=> (trial_q & $past(mask_q)) == $past(mask_q))
        else $error("trial bit not kept");
    next_trial_a: assert property (@(posedge clk) disable iff (rst)
        step_taken_s ##0 mask_q != 8'h01 |=> (trial_q & mask_q) == mask_q)
        else $error("next trial bit not set");
    step_gap_a: assert property (@(posedge clk) disable iff (rst)
        step_taken_s |=> !step [*3])
        else $error("decisions too close");
    dac_follow_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> dac_code == $past(trial_q))
        else $error("trial code not presented");
    conv_time_a: assert property (@(posedge clk) disable iff (rst)
        busy_cnt < SABC_CONV_MAX_CYC)
        else $error("conversion too long");

    // Done flag and bus
    done_low_a: assert property (@(posedge clk) disable iff (rst)
        done_entry_s |=> !eoc_n)
        else $error("done not marked");
    done_hold_a: assert property (@(posedge clk) disable iff (rst)
        done_held_s |=> state_q == SABC_DONE && $stable(trial_q))
        else $error("result not held while done");
    eoc_idle_a: assert property (@(posedge clk) disable iff (rst)
        !(start_s && state_q == SABC_DONE) |=> eoc_n)
        else $error("done low without result");
    busy_high_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == SABC_RUN) |=> eoc_n)
        else $error("done low while busy");
    hiz_off_a: assert property (@(posedge clk) disable iff (rst)
        !drive_s |=> bus.data_oe_n == 8'hff)
        else $error("outputs not released");
    drive_on_a: assert property (@(posedge clk) disable iff (rst)
        drive_s |=> bus.data_oe_n == 8'h00 && bus.data_out == $past(trial_q))
        else $error("result not driven");
endmodule

// ===== hw/sabc_pkg.sv
package sabc_pkg;
    localparam int unsigned SABC_BITS = 8;
    localparam int unsigned SABC_CLK_HZ = 20000000;
    localparam int unsigned SABC_CONV_MAX_NS = 2500;
    localparam int unsigned SABC_CLK_NS = 1000000000 / SABC_CLK_HZ;
    localparam int unsigned SABC_CONV_MAX_CYC = SABC_CONV_MAX_NS / SABC_CLK_NS;
    localparam logic [7:0] SABC_MID_CODE = 8'h80;
    localparam logic [7:0] SABC_RESET_CODE = 8'h00;
    localparam logic [7:0] SABC_BIT_DIV = 8'h03;

    typedef enum logic [1:0] {
        SABC_IDLE,
        SABC_RUN,
        SABC_DONE
    } sabc_state_t;

    typedef struct packed {
        logic [7:0] data_out;
        logic [7:0] data_oe_n;
    } sabc_bus_t;
endpackage

// ===== hw/sabc_sync.sv
`timescale 1ns/100ps
module sabc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== tb/sabc_front_model.sv
`timescale 1ns/100ps
module sabc_front_model (
    // Analog level and trial code
    input wire logic [7:0] vin,
    input wire logic [7:0] dac_code,
    // Comparator decision
    output logic cmp_above
);
    // Ideal comparator
    assign cmp_above = (vin >= dac_code);
endmodule

// ===== tb/sar_adc_bus_control_bench.sv
`timescale 1ns/100ps
module sar_adc_bus_control_bench;
    import sabc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, start_n = 1'b1, data_en_n = 1'b1, eoc_n, cmp_above;
    logic [7:0] dac_code, vin = 8'h00, rnd = 8'h28;
    sabc_bus_t bus;
    logic [7:0] corner [6] = '{8'h00, 8'h80, 8'hff, 8'h7f, 8'h01, 8'hfe};
    int n_fail = 0, n_compared = 0, cyc, runs;
    sabc_top dut (.clk(clk), .rst(rst), .start_n(start_n), .data_en_n(data_en_n), .eoc_n(eoc_n),
        .bus(bus), .cmp_above(cmp_above), .dac_code(dac_code));
    sabc_front_model front (.vin(vin), .dac_code(dac_code), .cmp_above(cmp_above));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] sar_code(logic [7:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (v >= (c | (8'h01 << b))) c = c | (8'h01 << b);
        end
        return c;
    endfunction
    function automatic logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic restart();
        start_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("eoc_reset", {7'h00, eoc_n}, 8'h01);
        start_n = 1'b1;
    endtask
    task automatic run(logic [7:0] v, int abort_at);
        @(negedge clk);
        vin = v;
        restart();
        if (abort_at > 0) begin
            repeat (abort_at) @(negedge clk);
            restart();
        end
        cyc = 0;
        while (eoc_n !== 1'b0 && cyc < 60) begin
            @(negedge clk);
            cyc++;
        end
        chk("conv_time", {7'h00, cyc inside {[9:SABC_CONV_MAX_CYC]}}, 8'h01);
        if (cyc >= 60) test_done();
        chk("result", bus.data_out, sar_code(v));
        chk("dac_code", dac_code, sar_code(v));
        data_en_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("oe_on", bus.data_oe_n, 8'h00);
        chk("bus_data", bus.data_out, sar_code(v));
        data_en_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("oe_off", bus.data_oe_n, 8'hff);
        chk("eoc_hold", {7'h00, eoc_n}, 8'h00);
    endtask
    task automatic mid_reset();
        restart();
        repeat (10) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk("eoc_rst", {7'h00, eoc_n}, 8'h01);
        chk("oe_rst", bus.data_oe_n, 8'hff);
        chk("data_rst", bus.data_out, SABC_RESET_CODE);
        chk("dac_rst", dac_code, SABC_RESET_CODE);
        rst = 1'b0;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk("oe_reset", bus.data_oe_n, 8'hff);
        foreach (corner[i]) begin
            run(corner[i], 0);
        end
        mid_reset();
        repeat (8) begin
            rnd = lfsr(rnd);
            run(rnd, rnd[0] ? int'(rnd[4:1]) + 1 : 0);
        end
        runs = 0;
        repeat (200) begin
            @(negedge clk);
            if (start_n === 1'b1 && eoc_n === 1'b0) runs++;
            start_n = eoc_n;
        end
        chk("free_runs", {7'h00, runs >= 3}, 8'h01);
        test_done();
    end
endmodule
